// ### pkg/ata_pins_pkg.sv
// Package for the disk channel pin engine: constants, carriers and states
package ata_pins_pkg;
  // Decode of the I/O space seen by the secondary channel
  localparam logic [15:0] cmd_block_base = 16'h0170;
  localparam logic [15:0] cmd_block_last = 16'h0177;
  localparam logic [15:0] ctl_block_addr = 16'h0376;
  localparam int addr_lsb_width = 3;
  localparam int data_width = 16;
  // Strobe timing in ns at 40 ns clock
  localparam int clk_period_ns = 40;
  localparam int strobe_active_ns = 165;
  localparam int strobe_recovery_ns = 70;
  localparam int strobe_active_cycles = (strobe_active_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int strobe_recovery_cycles = (strobe_recovery_ns + clk_period_ns - 1) / clk_period_ns;
  localparam logic [3:0] active_count = 4'(strobe_active_cycles);
  localparam logic [3:0] recovery_count = 4'(strobe_recovery_cycles);
  // Reset values of the pins
  localparam logic select_idle = 1'b1;
  localparam logic strobe_idle = 1'b1;

  typedef enum logic [1:0] {
    op_reg_read = 2'b00,
    op_reg_write = 2'b01,
    op_dma_read = 2'b10,
    op_dma_write = 2'b11
  } op_t;

  typedef struct packed {
    op_t op;
    logic [15:0] io_addr;
    logic [15:0] wdata;
  } request_t;

  typedef struct packed {
    logic command_block_select_n;
    logic control_block_select_n;
    logic disk_read_strobe_n;
    logic disk_write_strobe_n;
    logic disk_dma_ack_n;
  } control_pins_t;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_setup = 3'b001,
    st_active = 3'b010,
    st_recover = 3'b011,
    st_burst = 3'b100,
    st_stop = 3'b101
  } state_t;
endpackage

// ### rtl/ata_channel_pin_interface.sv
// Host end of one parallel disk channel: register cycles, multiword and synchronous DMA bursts
`timescale 1ns/1ps
// Contract
// - Synchronous read burst: ready is drive strobe; capture a word each edge.
// - Synchronous write burst: ready is drive DMARDY; host stops data while deasserted.
// - Cable-type level is sampled and held when software reads the status bit.
// - In single-channel two-device mode the secondary pin set serves the primary 1 connector.
// - Data bus and address lines float while reset is asserted.
// - Host presents a 3-bit address choosing the register within a block.
// - Command-block select asserts only for I/O addresses 170h through 177h.
// - Control-block select asserts only for 376h; other control addresses pass on.
// - Selects, strobes and DMA acknowledge held high in reset and suspend.
// - Read strobe lets drive drive the bus; host captures at strobe rise.
// - Host holds write data through write strobe; drive captures at its rise.
// - Drive addressed by selects with address lines, or by DMA acknowledge.
// - Synchronous read burst: read strobe pin is host DMARDY, deasserted to pause.
// - Synchronous write burst: read strobe pin is host strobe, toggling once per word.
// - Synchronous read burst: write strobe pin is STOP, asserted to end burst.
// - DMA acknowledge marks strobe cycles as DMA data transfers.
module ata_channel_pin_interface (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Mode
  input wire logic suspend_in,
  input wire logic single_channel_mode_in,
  input wire logic sync_dma_mode_in,
  input wire logic cable_status_read_in,
  // Request side
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire ata_pins_pkg::request_t req_in,
  input wire logic burst_end_in,
  // Read data stream
  output logic rdata_valid_out,
  input wire logic rdata_ready_in,
  output logic [15:0] rdata_out,
  output logic forward_to_isa_out,
  // Drive pins
  input wire logic [15:0] disk_data_bus_in,
  output logic [15:0] disk_data_bus_out,
  output logic disk_data_bus_oe_out,
  output logic [2:0] disk_address_out,
  output logic disk_address_oe_out,
  output ata_pins_pkg::control_pins_t pins_out,
  input wire logic secondary_channel_ready_in,
  input wire logic primary_channel_ready_in,
  input wire logic disk_dma_request_in,
  input wire logic secondary_cable_type_in,
  input wire logic primary_cable_type_in,
  // Status
  output logic [1:0] cable_status_out,
  output logic primary1_routed_out,
  output logic dma_request_out
);

  logic [1:0] ready_sync, next_ready_sync, pready_sync, next_pready_sync;
  logic [1:0] dreq_sync, next_dreq_sync, cab_sync, next_cab_sync, pcab_sync, next_pcab_sync;
  logic ready_prev, next_ready_prev;
  logic [15:0] din_s1, next_din_s1, din_s2, next_din_s2;
  ata_pins_pkg::state_t state, next_state;
  ata_pins_pkg::request_t cur, next_cur;
  ata_pins_pkg::control_pins_t pins, next_pins;
  logic [3:0] count, next_count;
  logic data_oe, next_data_oe, addr_oe, next_addr_oe;
  logic [15:0] dout, next_dout;
  logic [2:0] addr, next_addr;
  logic req_ready, next_req_ready, isa_fwd, next_isa_fwd;
  logic [1:0] cable, next_cable;
  logic routed, next_routed;
  logic [15:0] buf_data [2];
  logic [15:0] next_buf_data [2];
  logic [1:0] buf_cnt, next_buf_cnt;
  logic buf_rd, next_buf_rd;
  logic push;
  logic [15:0] push_data;
  logic pop;
  logic is_cmd, is_ctl, ready_edge;

  // Decode from the requested I/O address
  always_comb begin
    is_cmd = (cur.io_addr >= ata_pins_pkg::cmd_block_base) && (cur.io_addr <= ata_pins_pkg::cmd_block_last);
    // control select only on one address
    is_ctl = (cur.io_addr == ata_pins_pkg::ctl_block_addr);
    ready_edge = ready_sync[1] ^ ready_prev;
  end

  // Synchronisers: stage 0 is read only by stage 1
  always_comb begin
    next_ready_sync = {ready_sync[0], secondary_channel_ready_in};
    next_pready_sync = {pready_sync[0], primary_channel_ready_in};
    next_dreq_sync = {dreq_sync[0], disk_dma_request_in};
    next_cab_sync = {cab_sync[0], secondary_cable_type_in};
    next_pcab_sync = {pcab_sync[0], primary_cable_type_in};
    next_din_s1 = disk_data_bus_in;
    next_din_s2 = din_s1;
    next_ready_prev = ready_sync[1];
    next_cable = cable;
    // hold cable level at status read
    if (cable_status_read_in) begin
      next_cable = {pcab_sync[1], cab_sync[1]};
    end
    // secondary set routed to primary 1
    next_routed = single_channel_mode_in;
  end

  always_ff @(posedge clk_in) begin
    ready_sync <= next_ready_sync;
    pready_sync <= next_pready_sync;
    dreq_sync <= next_dreq_sync;
    cab_sync <= next_cab_sync;
    pcab_sync <= next_pcab_sync;
    din_s1 <= next_din_s1;
    din_s2 <= next_din_s2;
    ready_prev <= next_ready_prev;
    if (reset_in) begin
      cable <= 2'h0;
      routed <= 1'b0;
    end else begin
      cable <= next_cable;
      routed <= next_routed;
    end
  end

  // Cycle engine
  always_comb begin
    next_state = state;
    next_cur = cur;
    next_pins = pins;
    next_count = count;
    next_data_oe = data_oe;
    next_addr_oe = addr_oe;
    next_dout = dout;
    next_addr = addr;
    next_req_ready = 1'b0;
    next_isa_fwd = 1'b0;
    push = 1'b0;
    push_data = din_s2;
    unique case (state)
      ata_pins_pkg::st_idle: begin
        next_req_ready = 1'b1;
        if (req_valid_in && req_ready) begin
          next_req_ready = 1'b0;
          next_cur = req_in;
          next_state = ata_pins_pkg::st_setup;
        end
      end
      ata_pins_pkg::st_setup: begin
        next_count = ata_pins_pkg::active_count;
        next_addr = cur.io_addr[2:0];
        next_addr_oe = 1'b1;
        if (cur.op == ata_pins_pkg::op_reg_read || cur.op == ata_pins_pkg::op_reg_write) begin
          if (!is_cmd && !is_ctl) begin
            next_isa_fwd = 1'b1;
            next_state = ata_pins_pkg::st_idle;
          end else begin
            // drive addressed by select and address lines
            next_pins.command_block_select_n = !is_cmd;
            next_pins.control_block_select_n = !is_ctl;
            // write data driven through the strobe
            next_data_oe = (cur.op == ata_pins_pkg::op_reg_write);
            next_dout = cur.wdata;
            next_pins.disk_read_strobe_n = (cur.op == ata_pins_pkg::op_reg_write);
            next_pins.disk_write_strobe_n = (cur.op == ata_pins_pkg::op_reg_read);
            next_state = ata_pins_pkg::st_active;
          end
        end else if (dreq_sync[1]) begin
          // acknowledge marks DMA cycles; selects stay high
          next_pins.disk_dma_ack_n = 1'b0;
          next_pins.command_block_select_n = 1'b1;
          next_pins.control_block_select_n = 1'b1;
          next_data_oe = (cur.op == ata_pins_pkg::op_dma_write);
          next_dout = cur.wdata;
          if (sync_dma_mode_in) begin
            // read strobe as DMARDY, asserted when room exists
            next_pins.disk_read_strobe_n = (cur.op == ata_pins_pkg::op_dma_read) ? (buf_cnt == 2'h2) : 1'b1;
            next_pins.disk_write_strobe_n = 1'b1;
            next_state = ata_pins_pkg::st_burst;
          end else begin
            next_pins.disk_read_strobe_n = (cur.op == ata_pins_pkg::op_dma_write);
            next_pins.disk_write_strobe_n = (cur.op == ata_pins_pkg::op_dma_read);
            next_state = ata_pins_pkg::st_active;
          end
        end
      end
      ata_pins_pkg::st_active: begin
        if (count != 4'h0) begin
          next_count = count - 4'h1;
        end else if (ready_sync[1] && buf_cnt != 2'h2) begin
          // capture read data at strobe rise
          push = !cur.op[0];
          next_pins.disk_read_strobe_n = 1'b1;
          next_pins.disk_write_strobe_n = 1'b1;
          next_count = ata_pins_pkg::recovery_count;
          next_state = ata_pins_pkg::st_recover;
        end
      end
      ata_pins_pkg::st_recover: begin
        if (count != 4'h0) begin
          next_count = count - 4'h1;
        end else begin
          next_pins = '{default: ata_pins_pkg::select_idle};
          next_data_oe = 1'b0;
          next_state = ata_pins_pkg::st_idle;
        end
      end
      ata_pins_pkg::st_burst: begin
        if (cur.op == ata_pins_pkg::op_dma_read) begin
          // a word on each drive strobe edge
          push = ready_edge;
          // pause while the buffer holds any word or one arrives this cycle
          next_pins.disk_read_strobe_n = (buf_cnt != 2'h0) || push;
          if (burst_end_in) begin
            next_pins.disk_write_strobe_n = 1'b0;
            next_state = ata_pins_pkg::st_stop;
          end
        end else if (burst_end_in) begin
          next_state = ata_pins_pkg::st_stop;
        end else if (count != 4'h0) begin
          // drive DMARDY is active low; a pending word waits while it is negated
          if (!ready_sync[1]) begin
            // one toggle per word, data already standing a cycle
            next_pins.disk_read_strobe_n = !pins.disk_read_strobe_n;
            next_count = 4'h0;
          end
        end else if (req_valid_in && req_ready) begin
          // Count doubles as pending-word flag so data settles before its strobe edge
          next_dout = req_in.wdata;
          next_count = 4'h1;
        end
        if (cur.op == ata_pins_pkg::op_dma_write) begin
          next_req_ready = (next_count == 4'h0) && !burst_end_in;
        end
      end
      ata_pins_pkg::st_stop: begin
        next_count = ata_pins_pkg::recovery_count;
        next_state = ata_pins_pkg::st_recover;
      end
      default: begin
        next_state = ata_pins_pkg::st_idle;
      end
    endcase
    if (suspend_in) begin
      next_pins = '{default: ata_pins_pkg::strobe_idle};
      next_data_oe = 1'b0;
      next_req_ready = 1'b0;
      next_state = ata_pins_pkg::st_idle;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= ata_pins_pkg::st_idle;
      cur <= '0;
      pins <= '{default: ata_pins_pkg::select_idle};
      count <= 4'h0;
      data_oe <= 1'b0;
      addr_oe <= 1'b0;
      dout <= 16'h0000;
      addr <= 3'h0;
      req_ready <= 1'b0;
      isa_fwd <= 1'b0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      pins <= next_pins;
      count <= next_count;
      data_oe <= next_data_oe;
      addr_oe <= next_addr_oe;
      dout <= next_dout;
      addr <= next_addr;
      req_ready <= next_req_ready;
      isa_fwd <= next_isa_fwd;
    end
  end

  // Two-entry buffer so a stalled reader loses no word
  always_comb begin
    pop = buf_rd && rdata_ready_in;
    next_buf_data = buf_data;
    next_buf_cnt = buf_cnt;
    if (pop) begin
      next_buf_data[0] = buf_data[1];
      next_buf_cnt = next_buf_cnt - 2'h1;
    end
    if (push && next_buf_cnt != 2'h2) begin
      next_buf_data[next_buf_cnt[0]] = push_data;
      next_buf_cnt = next_buf_cnt + 2'h1;
    end
    next_buf_rd = (next_buf_cnt != 2'h0);
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      buf_data[0] <= 16'h0000;
      buf_data[1] <= 16'h0000;
      buf_cnt <= 2'h0;
      buf_rd <= 1'b0;
    end else begin
      buf_data <= next_buf_data;
      buf_cnt <= next_buf_cnt;
      buf_rd <= next_buf_rd;
    end
  end

  always_comb begin
    req_ready_out = req_ready;
    rdata_valid_out = buf_rd;
    rdata_out = buf_data[0];
    forward_to_isa_out = isa_fwd;
    disk_data_bus_out = dout;
    disk_data_bus_oe_out = data_oe;
    disk_address_out = addr;
    disk_address_oe_out = addr_oe;
    pins_out = pins;
    cable_status_out = cable;
    primary1_routed_out = routed;
    // request passed up, tied to no legacy channel
    dma_request_out = dreq_sync[1];
  end

endmodule // ata_channel_pin_interface

// ### verification/ata_drive_model.sv
// Behavioural disk drive on the far side of the channel pins
`timescale 1ns/1ps
module ata_drive_model (
  // Host pins
  input wire ata_pins_pkg::control_pins_t pins_in,
  input wire logic [2:0] addr_in,
  input wire logic [15:0] host_data_in,
  input wire logic host_oe_in,
  // Drive side
  output logic [15:0] bus_out,
  output logic ready_out,
  output logic dreq_out,
  output logic [15:0] got_out,
  output logic [7:0] got_count_out,
  output logic [7:0] late_out,
  input wire logic ask_in,
  input wire logic sync_in,
  input wire logic [15:0] delay_in
);
  logic [15:0] mem [16];
  logic [15:0] word = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic drv;
  logic [1:0] slot = 2'h0;
  time paused_at = 0;
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    ready_out = 1'b1;
    got_out = 16'h0000;
    got_count_out = 8'h00;
    late_out = 8'h00;
  end
  // drive takes a word on each host strobe edge of a write burst
  always @(pins_in.disk_read_strobe_n) begin
    if (sync_in && host_oe_in && !pins_in.disk_dma_ack_n) begin
      if (ready_out && $time - paused_at > 100) late_out = late_out + 8'h01;
      got_out = host_data_in;
      got_count_out = got_count_out + 8'h01;
    end
  end
  assign dreq_out = ask_in;
  assign drv = !pins_in.disk_read_strobe_n && (!pins_in.disk_dma_ack_n || !pins_in.command_block_select_n
    || !pins_in.control_block_select_n);
  // Released bus shows the inverse of its last level so a stale capture cannot pass
  always @(*) begin
    if (host_oe_in) bus_out = host_data_in;
    else if (drv) bus_out = pins_in.disk_dma_ack_n ? mem[{!pins_in.control_block_select_n, addr_in}] : word;
    else bus_out = ~last;
    if (host_oe_in || drv) last = bus_out;
  end
  always @(posedge pins_in.disk_write_strobe_n) begin
    if (pins_in.disk_dma_ack_n) mem[{!pins_in.control_block_select_n, addr_in}] = host_data_in;
  end
  always @(posedge pins_in.disk_read_strobe_n) begin
    if (!pins_in.disk_dma_ack_n && !sync_in) word = word + 16'h0001;
  end
  always @(negedge pins_in.disk_read_strobe_n or negedge pins_in.disk_write_strobe_n) begin
    if (pins_in.disk_dma_ack_n) begin
      ready_out = 1'b0;
      #(delay_in) ready_out = 1'b1;
    end
  end
  always begin
    #140;
    if (sync_in && !host_oe_in && !pins_in.disk_dma_ack_n && !pins_in.disk_read_strobe_n
      && pins_in.disk_write_strobe_n) begin
      word = word + 16'h0001;
      #20 ready_out = ~ready_out;
    end else if (sync_in && host_oe_in && !pins_in.disk_dma_ack_n) begin
      // negate DMARDY one slot in four to pause the host
      slot = slot + 2'h1;
      #20 ready_out = &slot;
      if (&slot) paused_at = $time;
    end else #20;
  end
endmodule // ata_drive_model

// ### verification/ata_channel_pin_interface_sva.sv
// Port assertions for the channel pin engine
`timescale 1ns/1ps
module ata_channel_pin_interface_sva (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Watched ports
  input wire logic suspend_in,
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire ata_pins_pkg::request_t req_in,
  input wire ata_pins_pkg::control_pins_t pins_out,
  input wire logic [15:0] disk_data_bus_out,
  input wire logic disk_data_bus_oe_out,
  input wire logic [2:0] disk_address_out,
  input wire logic disk_address_oe_out,
  input wire logic forward_to_isa_out
);
  ata_pins_pkg::request_t taken;
  logic cs;
  logic st;
  logic ack;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  always_ff @(posedge clk_in) begin
    if (reset_in) taken <= '0;
    else if (req_valid_in && req_ready_out) taken <= req_in;
  end
  assign cs = !pins_out.command_block_select_n || !pins_out.control_block_select_n;
  assign st = !pins_out.disk_read_strobe_n || !pins_out.disk_write_strobe_n;
  assign ack = !pins_out.disk_dma_ack_n;
  AST_RESET_IDLE: assert property (disable iff (1'b0) reset_in |=> pins_out == '1 && !disk_data_bus_oe_out
    && !disk_address_oe_out) else $error("pins not idle after reset");
  AST_SUSPEND_IDLE: assert property (suspend_in |=> pins_out == '1) else $error("pins active in suspend");
  AST_NO_OVERLAP: assert property (ack |-> !cs) else $error("select during dma ack");
  AST_CMD_RANGE: assert property (!pins_out.command_block_select_n |-> taken.io_addr inside {[16'h0170:16'h0177]})
    else $error("command select outside range");
  AST_CTL_ONLY: assert property (!pins_out.control_block_select_n |-> taken.io_addr == 16'h0376)
    else $error("control select off its address");
  AST_ADDR_FIELD: assert property (cs |-> disk_address_oe_out && disk_address_out == taken.io_addr[2:0])
    else $error("register address wrong");
  AST_STROBE_WIDTH: assert property ($fell(pins_out.disk_read_strobe_n) && cs |-> !pins_out.disk_read_strobe_n [*5])
    else $error("read strobe too short");
  AST_WRITE_HOLD: assert property (!pins_out.disk_write_strobe_n && cs |-> disk_data_bus_oe_out
    && disk_data_bus_out == taken.wdata) else $error("write data not held");
  AST_READ_RELEASE: assert property (!pins_out.disk_read_strobe_n && !ack |-> !disk_data_bus_oe_out)
    else $error("host drives bus on read");
  AST_DMA_MARK: assert property (st && !cs |-> ack) else $error("strobe without select or ack");
  AST_FORWARD_QUIET: assert property (forward_to_isa_out |-> pins_out == '1) else $error("pins move on forward");
  AST_WRITE_STROBE_DATA: assert property (ack && disk_data_bus_oe_out && $changed(pins_out.disk_read_strobe_n)
    |-> $stable(disk_data_bus_out)) else $error("write word moved with its strobe edge");
  AST_STOP_ENDS: assert property ($fell(pins_out.disk_write_strobe_n) && ack && !disk_data_bus_oe_out
    |-> ##[1:8] pins_out == '1) else $error("stop did not end the burst");
  cover property (ack && disk_data_bus_oe_out && $changed(pins_out.disk_read_strobe_n));
  cover property (cs && !pins_out.disk_write_strobe_n);
  cover property (ack && !pins_out.disk_read_strobe_n);
  cover property (forward_to_isa_out);
endmodule // ata_channel_pin_interface_sva
bind ata_channel_pin_interface ata_channel_pin_interface_sva ata_channel_pin_interface_sva_inst (.clk_in(clk_in),
  .reset_in(reset_in), .suspend_in(suspend_in), .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
  .req_in(req_in), .pins_out(pins_out), .disk_data_bus_out(disk_data_bus_out),
  .disk_data_bus_oe_out(disk_data_bus_oe_out), .disk_address_out(disk_address_out),
  .disk_address_oe_out(disk_address_oe_out), .forward_to_isa_out(forward_to_isa_out));

// ### verification/ata_channel_pin_interface_tb_top.sv
// Self-checking bench for the channel pin engine with a behavioural drive
`timescale 1ns/1ps
module ata_channel_pin_interface_tb_top;
  logic clk_in = 1'b0, reset_in = 1'b1, suspend = 1'b0, single = 1'b0, sync_mode = 1'b0, cable_read = 1'b0;
  logic req_valid = 1'b0, burst_end = 1'b0, rd_ready = 1'b0, ask = 1'b0, pcable = 1'b0, scable = 1'b0;
  ata_pins_pkg::request_t req = '0;
  ata_pins_pkg::control_pins_t pins;
  logic req_ready, rd_valid, fwd, oe, aoe, ready, routed, dreq, dreq_up, fwd_seen = 1'b0;
  logic [15:0] got;
  logic [15:0] wq [$];
  logic [7:0] got_n, late;
  logic [15:0] rdata, bus_out, bus_in, dly = 16'h0000;
  logic [2:0] addr;
  logic [1:0] cable;
  logic [31:0] seed = 32'h00007be2;
  logic [15:0] rq [$];
  int n_errors = 0, check_count = 0, cycles = 0, g;
  initial forever #20 clk_in = ~clk_in;
  ata_channel_pin_interface ata_channel_pin_interface_inst (.clk_in(clk_in), .reset_in(reset_in),
    .suspend_in(suspend), .single_channel_mode_in(single), .sync_dma_mode_in(sync_mode),
    .cable_status_read_in(cable_read), .req_valid_in(req_valid), .req_ready_out(req_ready), .req_in(req),
    .burst_end_in(burst_end), .rdata_valid_out(rd_valid), .rdata_ready_in(rd_ready), .rdata_out(rdata),
    .forward_to_isa_out(fwd), .disk_data_bus_in(bus_in), .disk_data_bus_out(bus_out), .disk_data_bus_oe_out(oe),
    .disk_address_out(addr), .disk_address_oe_out(aoe), .pins_out(pins), .secondary_channel_ready_in(ready),
    .primary_channel_ready_in(ready), .disk_dma_request_in(dreq), .secondary_cable_type_in(scable),
    .primary_cable_type_in(pcable), .cable_status_out(cable), .primary1_routed_out(routed),
    .dma_request_out(dreq_up));
  ata_drive_model ata_drive_model_inst (.pins_in(pins), .addr_in(addr), .host_data_in(bus_out), .host_oe_in(oe),
    .bus_out(bus_in), .ready_out(ready), .dreq_out(dreq), .got_out(got), .got_count_out(got_n),
    .late_out(late), .ask_in(ask), .sync_in(sync_mode), .delay_in(dly));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] nxt(input logic [15:0] p);
    return p + 16'h0001;
  endfunction
  task check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task complete_run();
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  task issue(input ata_pins_pkg::op_t op, input logic [15:0] a, input logic [15:0] d);
    req = '{op, a, d};
    req_valid = 1'b1;
    g = 0;
    do begin @(posedge clk_in); g++; end while (!req_ready && g < 300);
    #2 req_valid = 1'b0;
    g = 0;
    do begin tick(1); g++; end while (!req_ready && g < 600);
    check(16'(g < 600), 16'h0001);
  endtask
  task pop(output logic [15:0] w);
    g = 0;
    while (rq.size() == 0 && g < 100) begin tick(1); g++; end
    w = rq.size() ? rq.pop_front() : 16'hxxxx;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (rd_valid && rd_ready) rq.push_back(rdata);
    if (fwd) fwd_seen <= 1'b1;
    // Sized for the full sequence with slow drive answers
    if (cycles == 40000) begin n_errors++; complete_run(); end
  end
  // Random receiver stalls exercise the two-entry buffer
  always @(posedge clk_in) #2 rd_ready = rnd() % 4 != 0;
  // Words the drive took during write bursts, in order
  always @(got_n) begin
    if (got_n != 8'h00) wq.push_back(got);
  end
  initial begin
    logic [15:0] a, d, w, p;
    tick(16);
    reset_in = 1'b0;
    check({11'h000, pins}, 16'h001f);
    check({14'h0000, oe, aoe}, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      dly = (i % 2) ? 16'h0190 : 16'h0000;
      a = (i == 11) ? 16'h0376 : 16'h0170 + 16'(rnd() % 8);
      d = 16'(rnd());
      issue(ata_pins_pkg::op_reg_write, a, d);
      issue(ata_pins_pkg::op_reg_read, a, 16'h0000);
      pop(w);
      check(w, d);
    end
    issue(ata_pins_pkg::op_reg_read, 16'h0374, 16'h0000);
    issue(ata_pins_pkg::op_reg_write, 16'h0178, 16'h1234);
    check(16'(fwd_seen), 16'h0001);
    check(16'(rq.size()), 16'h0000);
    for (int m = 0; m < 2; m++) begin
      sync_mode = m[0];
      ask = 1'b1;
      // Join keeps each burst end inside its own scenario
      fork
        begin
          tick(80);
          burst_end = 1'b1;
          tick(1);
          burst_end = 1'b0;
        end
        issue(ata_pins_pkg::op_dma_read, 16'h0170, 16'h0000);
      join
      check(16'(dreq_up), 16'h0001);
      ask = 1'b0;
      tick(10);
      check(16'(dreq_up), 16'h0000);
      check(16'(rq.size() > 0), 16'h0001);
      p = rq.size() ? rq.pop_front() : 16'h0000;
      while (rq.size()) begin
        w = rq.pop_front();
        check(w, nxt(p));
        p = w;
      end
    end
    // Synchronous write burst: first word rides on the request, the rest stream behind it
    ask = 1'b1;
    d = 16'(rnd());
    issue(ata_pins_pkg::op_dma_write, 16'h0170, d);
    p = d;
    req_valid = 1'b1;
    repeat (23) begin
      p = nxt(p);
      req.wdata = p;
      g = 0;
      do begin
        @(posedge clk_in);
        g++;
      end while (!req_ready && g < 300);
      #2;
    end
    req_valid = 1'b0;
    tick(12);
    burst_end = 1'b1;
    tick(1);
    burst_end = 1'b0;
    ask = 1'b0;
    tick(10);
    check(16'(wq.size()), 16'h0018);
    check(16'(late), 16'h0000);
    p = d;
    while (wq.size()) begin
      w = wq.pop_front();
      check(w, p);
      p = nxt(p);
    end
    suspend = 1'b1;
    tick(3);
    check({11'h000, pins}, 16'h001f);
    suspend = 1'b0;
    single = 1'b1;
    scable = 1'b1;
    tick(4);
    check(16'(routed), 16'h0001);
    cable_read = 1'b1;
    tick(1);
    cable_read = 1'b0;
    tick(6);
    check(16'(cable), 16'h0001);
    scable = 1'b0;
    pcable = 1'b1;
    tick(6);
    check(16'(cable), 16'h0001);
    cable_read = 1'b1;
    tick(1);
    cable_read = 1'b0;
    tick(6);
    check(16'(cable), 16'h0002);
    complete_run();
  end
endmodule // ata_channel_pin_interface_tb_top
